// File: common/adcis_defs.vh
// constants for the converter input select and sequencing block
// included by the redundancy and top design files under hw/, not by the divider; definitions only
`ifndef ADCIS_DEFS_VH
`define ADCIS_DEFS_VH

// channel map
`define ADCIS_CH_BATT        3'h0
`define ADCIS_CH_TEMP        3'h1
`define ADCIS_CH_STD         3'h2
`define ADCIS_CH_INTREF      3'h3
`define ADCIS_CH_VREG        3'h4
`define ADCIS_CH_BRIDGE      3'h5
`define ADCIS_CH_HS1         3'h6
`define ADCIS_CH_HS2         3'h7

// gain codes presented to the attenuator
`define ADCIS_GAIN_76        7'h4c
`define ADCIS_GAIN_60        7'h3c
`define ADCIS_GAIN_50        7'h32
`define ADCIS_GAIN_38        7'h26
`define ADCIS_GAIN_ONE       7'h01

// converter sizes
`define ADCIS_RES_BITS       10
`define ADCIS_FULL_STEPS     12
`define ADCIS_CODE_MAX       10'h3ff
`define ADCIS_CODE_MIN       10'h000

// reset values
`define ADCIS_RESULT_RST     10'h200
`define ADCIS_DIV_RST        3'h1
`define ADCIS_STC_RST        3'h1

`endif

// File: hw/adcis_clkdiv.v
// converter clock enable divider
// one-cycle enable every div_ratio mclk cycles; ratio 0 treated as 1
`timescale 1ns/100ps
module adcis_clkdiv
(
  // clock and reset
  input  wire       mclk,
  input  wire       sys_rst,
  // control
  input  wire [2:0] div_ratio,
  input  wire       run,
  // enable out
  output reg        tick_r
);

reg  [2:0] cnt_r;
wire [2:0] lim = (div_ratio == 3'h0) ? 3'h0 : div_ratio - 3'h1;

always @(posedge mclk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    cnt_r  <= 3'h0;
    tick_r <= 1'b0;
  end
  else if (!run)
  begin
    cnt_r  <= 3'h0;
    tick_r <= 1'b0;
  end
  else if (cnt_r >= lim)
  begin
    cnt_r  <= 3'h0;
    tick_r <= 1'b1;
  end
  else
  begin
    cnt_r  <= cnt_r + 3'h1;
    tick_r <= 1'b0;
  end
end

endmodule // adcis_clkdiv

// File: hw/adcis_redund.v
// reduces redundant approximation decisions to a result code
// weights from 256 to 16 are a radix below two, from 16 to 1 binary with bits 1 and 0 both weight 1; sum clipped to the code range
`timescale 1ns/100ps
`include "adcis_defs.vh"
module adcis_redund
(
  // decisions, bit k of weight wt(k)
  input  wire [11:0] decide,
  input  wire [11:0] active,
  input  wire [9:0]  base,
  input  wire [9:0]  less,
  // result
  output reg  [9:0]  code,
  output reg         ovf,
  output reg         unf
);

// redundant step weights, overlapping ranges
function [9:0] wt;
  input [3:0] k;
  begin
    case (k)
      4'd11:   wt = 10'd256;
      4'd10:   wt = 10'd160;
      4'd9:    wt = 10'd96;
      4'd8:    wt = 10'd64;
      4'd7:    wt = 10'd40;
      4'd6:    wt = 10'd24;
      4'd5:    wt = 10'd16;
      4'd4:    wt = 10'd8;
      4'd3:    wt = 10'd4;
      4'd2:    wt = 10'd2;
      4'd1:    wt = 10'd1;
      default: wt = 10'd1;
    endcase
  end
endfunction

reg [12:0] sum;
integer    i;

always @*
begin
  sum = {3'h0, base} - {3'h0, less};
  for (i = 0; i < 12; i = i + 1)
  begin
    if (active[i] && decide[i])
      sum = sum + {3'h0, wt(i[3:0])};
  end
  ovf  = 1'b0;
  unf  = 1'b0;
  code = sum[9:0];
  if (sum[12])
  begin
    unf  = 1'b1;
    code = `ADCIS_CODE_MIN;
  end
  else if (sum[11:10] != 2'h0)
  begin
    ovf  = 1'b1;
    code = `ADCIS_CODE_MAX;
  end
end

endmodule // adcis_redund

// File: hw/adcis_top.v
// converter input select and conversion sequencer
// plain control ports from the processor side, comparator from the analog core
// Operation
// R1: mux routes exactly one signal and one reference channel per conversion
// R2: channels 6 and 7 are never used as reference
// R3: codes 11X use gain 76/60/50/38 by setting, others gain one
// R4: sensor supply of channel 6/7 on only while that channel is measured
// R5: settling delay separates supply on from sampling start; here sampling starts with supply on and the delay precedes conversion start
// R6: reference 5 with input 6/7 connects that input's negative bridge return
// R7: channel map fixed: battery, temperature, standard, reference, regulator, bridge
// R8: each signal channel selectable differential or single ended
// R9: full conversion does 12 redundant decisions giving a 10-bit code
// R10: sub conversion starts from previous result, deciding only low positions
// R11: polarity bit inverts comparator input for offset averaging
// R12: start bit latched on converter clock, then busy, sample, result written
// R13: reference and signal channel each from own three-bit field
// R14: full/sub select, bit count field; upper bits kept less half range
// R15: overflow and underflow saturate with separate status flags
// R16: start ignored while busy; busy clears after result stable
`timescale 1ns/100ps
`include "adcis_defs.vh"
module adcis_top
#(
  parameter DIV_W = 3,
  parameter STC_W = 3
)
(
  // clock and reset
  input  wire             mclk,
  input  wire             sys_rst,
  // software control
  input  wire             conversion_trigger,
  input  wire [2:0]       signal_channel_code,
  input  wire [2:0]       reference_channel_code,
  input  wire [1:0]       sensitivity_gain_code,
  input  wire             diff_select,
  input  wire             polarity_invert,
  input  wire             full_or_partial_select,
  input  wire [2:0]       partial_bit_count,
  input  wire [DIV_W-1:0] clock_div_ratio,
  input  wire [STC_W-1:0] settle_count,
  // analog core
  input  wire             comparator_out,
  // mux and attenuator controls
  output reg  [2:0]       mux_signal_sel_r,
  output reg  [2:0]       mux_ref_sel_r,
  output reg  [6:0]       gain_value_r,
  output reg              single_ended_r,
  output reg              comp_invert_r,
  output reg              sensor_return_one_r,
  output reg              sensor_return_two_r,
  output reg              bridge_neg_one_r,
  output reg              bridge_neg_two_r,
  output reg              sample_hold_r,
  output reg  [9:0]       dac_code_r,
  // status
  output reg              busy_r,
  output reg              sample_r,
  output reg              overflow_r,
  output reg              underflow_r,
  output reg              ref_error_r,
  output reg  [9:0]       result_r
);

// sequencer states
localparam S_IDLE   = 5'b00001;
localparam S_SETTLE = 5'b00010;
localparam S_CONV   = 5'b00100;
localparam S_WRITE  = 5'b01000;
localparam S_STABLE = 5'b10000;

reg  [4:0]  state_r;
reg  [4:0]  state_nxt;
reg  [STC_W-1:0] settle_r;
reg  [3:0]  step_r;
reg  [11:0] decide_r;
reg  [11:0] active_r;
reg  [9:0]  base_r;
reg  [9:0]  less_r;
reg         trig_sync1_r;
reg         trig_sync2_r;
reg         trig_prev_r;
reg         cmp_sync1_r;
reg         cmp_sync2_r;
reg         pending_r;
wire        tick;
wire [9:0]  code;
wire        ovf;
wire        unf;

// comparator from analog core crosses into mclk
always @(posedge mclk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    cmp_sync1_r  <= 1'b0;
    cmp_sync2_r  <= 1'b0;
    trig_sync1_r <= 1'b0;
    trig_sync2_r <= 1'b0;
    trig_prev_r  <= 1'b0;
  end
  else
  begin
    cmp_sync1_r  <= comparator_out;
    cmp_sync2_r  <= cmp_sync1_r;
    trig_sync1_r <= conversion_trigger;
    trig_sync2_r <= trig_sync1_r;
    trig_prev_r  <= trig_sync2_r;
  end
end

wire trig_rise = trig_sync2_r & ~trig_prev_r;
// R11: polarity inversion undone on decision
wire decision  = cmp_sync2_r ^ comp_invert_r;
// R2: reference on 6 or 7 refused
wire ref_bad   = (reference_channel_code[2:1] == 2'b11);

// R12: converter clock enable; start latched on its edge
adcis_clkdiv u_div
(
  .mclk      (mclk),
  .sys_rst   (sys_rst),
  .div_ratio (clock_div_ratio),
  .run       (1'b1),
  .tick_r    (tick)
);

// R9: decisions reduced to 10-bit code
adcis_redund u_red
(
  .decide (decide_r),
  .active (active_r),
  .base   (base_r),
  .less   (less_r),
  .code   (code),
  .ovf    (ovf),
  .unf    (unf)
);

// R10: number of low positions decided in a sub conversion
wire [3:0] sub_steps = (partial_bit_count == 3'h0) ? 4'h8 : {1'b0, partial_bit_count};

// half the sub range, subtracted from the base
wire [9:0] half_sub  = 10'h001 << (sub_steps - 4'h1);

always @*
begin
  state_nxt = state_r;
  case (state_r)
    S_IDLE:
      // R16: new start only from idle
      if (pending_r && tick && !ref_bad)
        state_nxt = S_SETTLE;
    S_SETTLE:
      // R5: wait programmed settling ticks
      if (tick && settle_r == {STC_W{1'b0}})
        state_nxt = S_CONV;
    S_CONV:
      if (tick && step_r == 4'h0)
        state_nxt = S_WRITE;
    S_WRITE:
      if (tick)
        state_nxt = S_STABLE;
    S_STABLE:
      if (tick)
        state_nxt = S_IDLE;
    default:
      state_nxt = S_IDLE;
  endcase
end

always @(posedge mclk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    state_r             <= S_IDLE;
    pending_r           <= 1'b0;
    settle_r            <= {STC_W{1'b0}};
    step_r              <= 4'h0;
    decide_r            <= 12'h000;
    active_r            <= 12'h000;
    base_r              <= `ADCIS_CODE_MIN;
    less_r              <= `ADCIS_CODE_MIN;
    mux_signal_sel_r    <= `ADCIS_CH_BATT;
    mux_ref_sel_r       <= `ADCIS_CH_INTREF;
    gain_value_r        <= `ADCIS_GAIN_ONE;
    single_ended_r      <= 1'b1;
    comp_invert_r       <= 1'b0;
    sensor_return_one_r <= 1'b0;
    sensor_return_two_r <= 1'b0;
    bridge_neg_one_r    <= 1'b0;
    bridge_neg_two_r    <= 1'b0;
    sample_hold_r       <= 1'b0;
    dac_code_r          <= `ADCIS_CODE_MIN;
    busy_r              <= 1'b0;
    sample_r            <= 1'b0;
    overflow_r          <= 1'b0;
    underflow_r         <= 1'b0;
    ref_error_r         <= 1'b0;
    result_r            <= `ADCIS_RESULT_RST;
  end
  else
  begin
    state_r <= state_nxt;
    // R16: request seen while busy is dropped
    if (trig_rise && !busy_r)
      pending_r <= 1'b1;
    else if (state_r == S_IDLE && tick)
      pending_r <= 1'b0;
    if (state_r == S_IDLE && pending_r && tick)
    begin
      // R2: refuse reference on a high-sensitivity channel
      ref_error_r <= ref_bad;
      if (!ref_bad)
      begin
        // R1: latch one signal and one reference channel
        // R13: from their own fields; R7 map fixed by code value
        mux_signal_sel_r <= signal_channel_code;
        mux_ref_sel_r    <= reference_channel_code;
        // R8: differential or single ended
        single_ended_r   <= ~diff_select;
        comp_invert_r    <= polarity_invert;
        // R3: gain only for codes 11X
        if (signal_channel_code[2:1] == 2'b11)
        begin
          case (sensitivity_gain_code)
            2'h0:    gain_value_r <= `ADCIS_GAIN_76;
            2'h1:    gain_value_r <= `ADCIS_GAIN_60;
            2'h2:    gain_value_r <= `ADCIS_GAIN_50;
            default: gain_value_r <= `ADCIS_GAIN_38;
          endcase
        end
        else
          gain_value_r <= `ADCIS_GAIN_ONE;
        // R4: supply only for the channel measured
        sensor_return_one_r <= (signal_channel_code == `ADCIS_CH_HS1);
        sensor_return_two_r <= (signal_channel_code == `ADCIS_CH_HS2);
        // R6: bridge return follows the input when reference is 5
        bridge_neg_one_r <= (reference_channel_code == `ADCIS_CH_BRIDGE)
                            && (signal_channel_code == `ADCIS_CH_HS1);
        bridge_neg_two_r <= (reference_channel_code == `ADCIS_CH_BRIDGE)
                            && (signal_channel_code == `ADCIS_CH_HS2);
        settle_r      <= settle_count;
        busy_r        <= 1'b1;
        sample_r      <= 1'b1;
        sample_hold_r <= 1'b1;
        decide_r      <= 12'h000;
        // R14: full or sub conversion set-up
        if (full_or_partial_select)
        begin
          // R10: keep previous result less half the sub range
          // the difference may go below zero; the reducer then flags underflow
          base_r   <= result_r;
          less_r   <= half_sub;
          step_r   <= sub_steps - 4'h1;
          active_r <= (12'h001 << sub_steps) - 12'h001;
        end
        else
        begin
          // R9: twelve decisions from zero
          base_r   <= `ADCIS_CODE_MIN;
          less_r   <= `ADCIS_CODE_MIN;
          step_r   <= 4'd11;
          active_r <= 12'hfff;
        end
      end
    end
    if (state_r == S_SETTLE && tick && settle_r != {STC_W{1'b0}})
      settle_r <= settle_r - {{(STC_W-1){1'b0}}, 1'b1};
    if (state_r == S_SETTLE && state_nxt == S_CONV)
    begin
      sample_hold_r <= 1'b0;
      sample_r      <= 1'b0;
    end
    if (state_r == S_CONV && tick)
    begin
      // R9: one decision per converter clock
      decide_r[step_r] <= decision;
      if (step_r != 4'h0)
        step_r <= step_r - 4'h1;
    end
    dac_code_r <= code;
    if (state_r == S_WRITE && tick)
    begin
      // R15: saturated result and separate flags
      result_r    <= code;
      overflow_r  <= ovf;
      underflow_r <= unf;
    end
    if (state_r == S_STABLE && tick)
    begin
      // R16: busy clears one converter tick after result written
      busy_r              <= 1'b0;
      // R4: supply off after measurement
      sensor_return_one_r <= 1'b0;
      sensor_return_two_r <= 1'b0;
      bridge_neg_one_r    <= 1'b0;
      bridge_neg_two_r    <= 1'b0;
    end
  end
end

endmodule // adcis_top

// File: verification/adcis_top_asserts.sv
// assertions on the select and sequencer outputs of adcis_top
// bound to adcis_top below; sees its ports only
`timescale 1ns/100ps
module adcis_top_asserts
(
  // clock and reset
  input wire       mclk,
  input wire       sys_rst,
  // watched outputs
  input wire [2:0] mux_signal_sel_r,
  input wire [2:0] mux_ref_sel_r,
  input wire [6:0] gain_value_r,
  input wire       sensor_return_one_r,
  input wire       sensor_return_two_r,
  input wire       bridge_neg_one_r,
  input wire       busy_r,
  input wire       sample_r,
  input wire       overflow_r,
  input wire       underflow_r,
  input wire [9:0] result_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  supply_one_a: assert property (
    sensor_return_one_r |-> busy_r && mux_signal_sel_r == 3'h6)
    else $error("supply one on outside its conversion");
  supply_two_a: assert property (
    sensor_return_two_r |-> busy_r && mux_signal_sel_r == 3'h7)
    else $error("supply two on outside its conversion");
  settle_start_a: assert property (
    $rose(sensor_return_one_r) |-> sample_r)
    else $error("supply switched on without sampling phase");
  ref_legal_a: assert property (
    busy_r |-> mux_ref_sel_r[2:1] != 2'h3)
    else $error("high sensitivity channel used as reference");
  unit_gain_a: assert property (
    busy_r && mux_signal_sel_r[2:1] != 2'h3 |-> gain_value_r == 7'h01)
    else $error("gain not one on ordinary channel");
  bridge_pick_a: assert property (
    bridge_neg_one_r |-> busy_r && mux_ref_sel_r == 3'h5 && mux_signal_sel_r == 3'h6)
    else $error("bridge return one on without its pairing");
  result_hold_a: assert property (
    !busy_r ##1 !busy_r |-> $stable(result_r))
    else $error("result changed while idle");
  sat_codes_a: assert property (
    (overflow_r |-> result_r == 10'h3ff) and (underflow_r |-> result_r == 10'h000))
    else $error("saturation code wrong");
  flag_excl_a: assert property (
    !(overflow_r && underflow_r))
    else $error("both range flags set");
endmodule // adcis_top_asserts

bind adcis_top adcis_top_asserts u_chk
(
  .mclk(mclk), .sys_rst(sys_rst), .mux_signal_sel_r(mux_signal_sel_r),
  .mux_ref_sel_r(mux_ref_sel_r), .gain_value_r(gain_value_r),
  .sensor_return_one_r(sensor_return_one_r), .sensor_return_two_r(sensor_return_two_r),
  .bridge_neg_one_r(bridge_neg_one_r), .busy_r(busy_r), .sample_r(sample_r),
  .overflow_r(overflow_r), .underflow_r(underflow_r), .result_r(result_r)
);

// File: verification/adcis_comp_model.sv
// analog core stand-in: comparator with a fixed input level
// level is set by the bench; decisions change only after mclk edges
`timescale 1ns/100ps
module adcis_comp_model
(
  // clock
  input wire mclk,
  // analog side
  input wire level,
  input wire invert,
  // decision out
  output reg comparator_out
);
  initial comparator_out = 1'b0;
  always @(posedge mclk)
    comparator_out <= level ^ invert;
endmodule // adcis_comp_model

// File: verification/test_adcis_top.sv
// self-checking bench for adcis_top with the comparator model
// inputs change at the falling edge of mclk
`timescale 1ns/100ps
module test_adcis_top;
  reg        mclk = 1'b0, sys_rst = 1'b1, trig = 1'b0, diff = 1'b0, pol = 1'b0;
  reg        fp = 1'b0, level = 1'b0, pb = 1'b0;
  reg  [2:0] sig = 3'h0, rsel = 3'h0, nb = 3'h0, dv = 3'h2, stc = 3'h2;
  reg  [1:0] gain = 2'h0;
  reg        s1, s2, b1, b2, se, ci, smp;
  reg  [6:0] gseen;
  integer    nrise, slen, hlen, error_cnt = 0, check_count = 0, i;
  wire       comp, busy_r, sample_r, overflow_r, underflow_r, ref_error_r;
  wire       single_ended_r, comp_invert_r, sr1, sr2, bn1, bn2, shold;
  wire [2:0] msig, mref;
  wire [6:0] gain_value_r;
  wire [9:0] result_r, dac;

  always #2.5 mclk = ~mclk;

  adcis_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .conversion_trigger(trig),
    .signal_channel_code(sig), .reference_channel_code(rsel), .sensitivity_gain_code(gain),
    .diff_select(diff), .polarity_invert(pol), .full_or_partial_select(fp),
    .partial_bit_count(nb), .clock_div_ratio(dv), .settle_count(stc),
    .comparator_out(comp), .mux_signal_sel_r(msig), .mux_ref_sel_r(mref),
    .gain_value_r(gain_value_r), .single_ended_r(single_ended_r),
    .comp_invert_r(comp_invert_r), .sensor_return_one_r(sr1), .sensor_return_two_r(sr2),
    .bridge_neg_one_r(bn1), .bridge_neg_two_r(bn2), .sample_hold_r(shold), .dac_code_r(dac),
    .busy_r(busy_r), .sample_r(sample_r), .overflow_r(overflow_r),
    .underflow_r(underflow_r), .ref_error_r(ref_error_r), .result_r(result_r));

  adcis_comp_model u_comp (.mclk(mclk), .level(level), .invert(comp_invert_r),
    .comparator_out(comp));

  // sticky flags, counts and last values observed during a conversion
  always @(posedge mclk)
  begin
    pb <= busy_r;
    if (busy_r && !pb)
      nrise <= nrise + 1;
    if (busy_r)
    begin
      {s1, s2, b1, b2} <= {s1 | sr1, s2 | sr2, b1 | bn1, b2 | bn2};
      {se, ci, smp} <= {single_ended_r, comp_invert_r, smp | sample_r};
      gseen <= gain_value_r;
      slen <= slen + sample_r;
      hlen <= hlen + shold;
    end
  end

  task chk(input [11:0] got, input [11:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task cfg(input [2:0] s, input [2:0] r, input [1:0] g, input p, input f, input [2:0] n,
           input lv);
    {sig, rsel, gain, pol, fp, nb, level, diff} = {s, r, g, p, f, n, lv, s[2] & s[1]};
  endtask

  // one start pulse, a second one during busy if asked
  task run_conv(input again);
    integer n;
    begin
      {s1, s2, b1, b2, se, ci, smp, gseen, nrise, slen, hlen} = 0;
      trig = 1'b1;
      repeat (4) @(negedge mclk);
      trig = 1'b0;
      n = 0;
      while (!busy_r && n < 20)
      begin
        @(negedge mclk);
        n = n + 1;
      end
      if (again)
      begin
        trig = 1'b1;
        repeat (4) @(negedge mclk);
        trig = 1'b0;
      end
      while (busy_r && n < 400)
      begin
        @(negedge mclk);
        n = n + 1;
      end
      if (busy_r)
      begin
        error_cnt = error_cnt + 1;
        $display("BAD %0t busy never cleared", $time);
      end
      repeat (20) @(negedge mclk);
    end
  endtask

  task give_verdict;
    begin
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  initial
  begin
    #100000;
    error_cnt = error_cnt + 1;
    $display("BAD %0t watchdog expired", $time);
    give_verdict;
  end

  initial
  begin
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    chk(mref, 10'h3); chk(gain_value_r, 10'h1); chk(result_r, 10'h200);
    // high sensitivity channels, every gain code, bridge reference
    for (i = 0; i < 4; i = i + 1)
    begin
      cfg(3'h6 | i[0], 3'h5, i[1:0], 1'b0, 1'b0, 3'h0, 1'b1);
      run_conv(1'b0);
      chk(gseen, i == 0 ? 7'h4c : i == 1 ? 7'h3c : i == 2 ? 7'h32 : 7'h26);
      chk({s1, s2}, {~i[0], i[0]});
      chk({b1, b2}, {~i[0], i[0]});
      chk({se, smp, nrise[1:0]}, 10'h5);
      chk(result_r, 10'h2a0);
      chk(dac, 10'h2a0);
      chk({hlen[5:0], slen[5:0]}, 12'h186);
    end
    // fastest converter clock, no extra settling
    {dv, stc} = {3'h1, 3'h0};
    cfg(3'h2, 3'h3, 2'h3, 1'b0, 1'b0, 3'h0, 1'b0);
    run_conv(1'b0);
    chk({s1, s2, b1, se, gseen}, {4'h1, 7'h01});
    chk({result_r, underflow_r}, 11'h0);
    chk({hlen[5:0], slen[5:0]}, 12'h041);
    {dv, stc} = {3'h2, 3'h2};
    // sub conversion below zero from a zero result
    cfg(3'h2, 3'h3, 2'h0, 1'b0, 1'b1, 3'h4, 1'b0);
    run_conv(1'b0);
    chk({overflow_r, underflow_r, result_r}, 12'h400);
    // second start during busy is dropped
    cfg(3'h1, 3'h3, 2'h0, 1'b0, 1'b0, 3'h0, 1'b0);
    run_conv(1'b1);
    chk(nrise, 10'h1);
    chk(underflow_r, 10'h0);
    // references six and seven refused
    for (i = 6; i < 8; i = i + 1)
    begin
      cfg(3'h6, i[2:0], 2'h0, 1'b0, 1'b0, 3'h0, 1'b0);
      run_conv(1'b0);
      chk({ref_error_r, nrise[0], s1}, 10'h4);
    end
    cfg(3'h7, 3'h5, 2'h0, 1'b1, 1'b0, 3'h0, 1'b1);
    run_conv(1'b0);
    chk({ci, ref_error_r}, 10'h2);
    chk(result_r, 10'h2a0);
    give_verdict;
  end
endmodule // test_adcis_top
